/* trxd_defines.svh */
// Purpose: constants shared by both ends of the receive debug port set
// Assumes: one 10 MHz user clock, counts in cycles of it
// Notes: config port clock taken as the user clock here
`ifndef TRXD_DEFINES_SVH
`define TRXD_DEFINES_SVH
`define TRXD_CFG_TIMEOUT_CYC 500
`define TRXD_CNT_W 9
`define TRXD_PMA_DONE_CYC 16
`define TRXD_PRBS_SEL_W 3
`define TRXD_CFG_RST_BIT 2
`define TRXD_RSVD_W 16
`define TRXD_BOOST_W 4
`define TRXD_BOOST_CFG_RST 4'h8
`define TRXD_PULSE_CYC 2
`define TRXD_ERR_W 8
`endif

/* trxd_pkg.sv */
// Purpose: types shared by both ends
// Assumes: nothing
// Notes: defines header carries the numbers
`include "trxd_defines.svh"
package trxd_pkg;
   typedef enum logic [1:0] {trxd_idle, trxd_high, trxd_low} trxd_pulse_st_t;
   typedef logic [`TRXD_PRBS_SEL_W-1:0] trxd_prbs_sel_t;
endpackage

/* trxd_if.sv */
// Purpose: wires between the transceiver debug end and user logic end
// Assumes: all signals sampled on mclk_in
// Notes: no clocking block
`timescale 1ns/10ps
`include "trxd_defines.svh"
interface trxd_if;
   logic hf_boost_override_select;
   logic [`TRXD_BOOST_W-1:0] hf_boost_hold;
   logic lpm_eq_reset;
   logic prbs_err;
   trxd_pkg::trxd_prbs_sel_t prbs_sel;
   logic rx_pcs_reset;
   logic rx_pma_reset;
   logic rx_pma_reset_done;
   logic rx_full_reset;
   logic rx_buf_reset;
   logic [`TRXD_RSVD_W-1:0] pcs_reserved;
   logic config_port_ready;
   modport dev (input hf_boost_override_select, hf_boost_hold, lpm_eq_reset, prbs_sel,
      rx_pcs_reset, rx_pma_reset, rx_full_reset, rx_buf_reset, pcs_reserved,
      output prbs_err, rx_pma_reset_done, config_port_ready);
   modport user (output hf_boost_override_select, hf_boost_hold, lpm_eq_reset, prbs_sel,
      rx_pcs_reset, rx_pma_reset, rx_full_reset, rx_buf_reset, pcs_reserved,
      input prbs_err, rx_pma_reset_done, config_port_ready);
endinterface

/* trxd_user.sv */
// Purpose: user logic end: drives reset pulses and watches config port
// Assumes: user requests are one-cycle pulses on mclk_in
// Notes: pcs, pma and buffer reset requests become a high pulse then low; full and lpm resets follow inputs
`timescale 1ns/10ps
`include "trxd_defines.svh"
module trxd_user (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   trxd_if.user link,
   input wire logic boost_override_in,
   input wire logic [`TRXD_BOOST_W-1:0] boost_hold_in,
   input wire logic lpm_reset_in,
   input wire logic [`TRXD_PRBS_SEL_W-1:0] prbs_sel_in,
   input wire logic pcs_reset_req_in,
   input wire logic pma_reset_req_in,
   input wire logic buf_reset_req_in,
   input wire logic full_reset_in,
   input wire logic cfg_start_in,
   output logic prbs_err_out,
   output logic pma_done_out,
   output logic cfg_timeout_out
);
   typedef struct packed {
      logic ovr;
      logic [`TRXD_BOOST_W-1:0] hold;
      logic lpm;
      logic [`TRXD_PRBS_SEL_W-1:0] sel;
      logic pcs;
      logic pma;
      logic bufr;
      logic full;
      logic cfg_rst;
      logic busy;
      logic [`TRXD_CNT_W-1:0] cnt;
      logic err;
      logic done;
      logic tmo;
   } trxd_user_st_t;
   trxd_user_st_t st;
   trxd_user_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.ovr = boost_override_in;
      next_st.hold = boost_hold_in;
      next_st.lpm = lpm_reset_in;
      next_st.sel = prbs_sel_in;
      next_st.full = full_reset_in;
      // one registered cycle high, then low next cycle
      next_st.pcs = pcs_reset_req_in & ~st.pcs; // R5 R11
      next_st.pma = pma_reset_req_in & ~st.pma; // R6 R11
      next_st.bufr = buf_reset_req_in & ~st.bufr; // R8 R11
      next_st.cfg_rst = 1'b0;
      next_st.tmo = 1'b0;
      if (cfg_start_in && !st.busy) begin
         next_st.busy = 1'b1;
         next_st.cnt = '0;
      end else if (st.busy) begin
         if (link.config_port_ready) begin
            next_st.busy = 1'b0;
         end else if (st.cnt == `TRXD_CNT_W'(`TRXD_CFG_TIMEOUT_CYC - 1)) begin
            next_st.busy = 1'b0;
            next_st.cfg_rst = 1'b1; // R9
            next_st.tmo = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end
      next_st.err = link.prbs_err;
      next_st.done = link.rx_pma_reset_done;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign link.hf_boost_override_select = st.ovr;
   assign link.hf_boost_hold = st.hold;
   assign link.lpm_eq_reset = st.lpm;
   assign link.prbs_sel = st.sel;
   assign link.rx_pcs_reset = st.pcs;
   assign link.rx_pma_reset = st.pma;
   assign link.rx_buf_reset = st.bufr;
   assign link.rx_full_reset = st.full;
   assign link.pcs_reserved = `TRXD_RSVD_W'(st.cfg_rst) << `TRXD_CFG_RST_BIT;
   assign prbs_err_out = st.err;
   assign pma_done_out = st.done;
   assign cfg_timeout_out = st.tmo;
endmodule

/* trxd_dev.sv */
// Purpose: receive debug port set of the transceiver wrapper
// Assumes: ports always present; debug option clear holds their state at zero
// Notes: async inputs taken as synchronous per house setting
//
// How it works
// [R1] override high: static boost config; low: hold
// [R2] low-power reset clears equaliser state
// [R3] prbs error flag live, never latched
// [R4] pattern select chooses checked prbs pattern
// [R5] user pulses pcs reset high then low
// [R6] user pulses pma reset high then low
// [R7] pma done low during full or pma reset
// [R8] buffer reset pulse clears only elastic buffer
// [R9] user resets config port after 500-cycle timeout
// [R10] debug option clear holds all port state at zero
// [R11] user holds reset pulses a full cycle
`timescale 1ns/10ps
`include "trxd_defines.svh"
module trxd_dev #(
   parameter bit DEBUG_PORTS_EN = 1'b1
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   trxd_if.dev link,
   input wire logic rx_bit_in,
   input wire logic cfg_req_in,
   output logic [`TRXD_BOOST_W-1:0] hf_boost_out,
   output logic [`TRXD_BOOST_W-1:0] eq_state_out,
   output logic pcs_reset_out,
   output logic buf_reset_out,
   output logic [`TRXD_ERR_W-1:0] buf_level_out
);
   typedef struct packed {
      logic [`TRXD_BOOST_W-1:0] boost;
      logic [`TRXD_BOOST_W-1:0] eq;
      logic [6:0] lfsr;
      trxd_pkg::trxd_prbs_sel_t sel;
      logic err;
      logic pcs_d;
      logic pcs_rst;
      logic pma_d;
      logic pma_busy;
      logic [`TRXD_CNT_W-1:0] pma_cnt;
      logic pma_done;
      logic buf_d;
      logic buf_rst;
      logic [`TRXD_ERR_W-1:0] buf_lvl;
      logic cfg_rdy;
   } trxd_dev_st_t;
   trxd_dev_st_t st;
   trxd_dev_st_t next_st;
   logic fb;

   always_comb begin
      next_st = st;
      fb = 1'b0;
      // R1
      next_st.boost = link.hf_boost_override_select ? `TRXD_BOOST_CFG_RST : link.hf_boost_hold;
      if (link.lpm_eq_reset) begin
         next_st.eq = '0; // R2
      end else begin
         next_st.eq = st.eq + ((st.boost > st.eq) ? 1'b1 : 1'b0);
      end
      // select change swaps the checker taps; the shift history is kept
      next_st.sel = link.prbs_sel; // R4
      unique case (st.sel[1:0])
         2'h0: fb = st.lfsr[6] ^ st.lfsr[5];
         2'h1: fb = st.lfsr[6] ^ st.lfsr[4];
         2'h2: fb = st.lfsr[6] ^ st.lfsr[2];
         2'h3: fb = st.lfsr[6] ^ st.lfsr[0];
      endcase
      next_st.lfsr = {st.lfsr[5:0], rx_bit_in};
      // live compare each cycle, nothing holds it
      next_st.err = (st.sel != '0) && (rx_bit_in != fb); // R3
      next_st.pcs_d = link.rx_pcs_reset;
      next_st.pcs_rst = st.pcs_d & ~link.rx_pcs_reset; // R5
      next_st.pma_d = link.rx_pma_reset;
      if (link.rx_full_reset || link.rx_pma_reset) begin
         next_st.pma_done = 1'b0; // R7
         next_st.pma_busy = link.rx_full_reset;
         next_st.pma_cnt = '0;
      end else if (st.pma_d || st.pma_busy) begin
         next_st.pma_busy = 1'b1; // R6
         if (st.pma_cnt == `TRXD_CNT_W'(`TRXD_PMA_DONE_CYC - 1)) begin
            next_st.pma_busy = 1'b0;
            next_st.pma_done = 1'b1; // R7
         end else begin
            next_st.pma_cnt = st.pma_cnt + 1'b1;
         end
      end
      next_st.buf_d = link.rx_buf_reset;
      next_st.buf_rst = st.buf_d & ~link.rx_buf_reset; // R8
      // only the elastic buffer level clears; pcs and pma untouched
      if (next_st.buf_rst) begin
         next_st.buf_lvl = '0; // R8
      end else begin
         next_st.buf_lvl = st.buf_lvl + 1'b1;
      end
      // config port stalls while its reset bit is high
      next_st.cfg_rdy = cfg_req_in & ~link.pcs_reserved[`TRXD_CFG_RST_BIT]; // R9
      if (!DEBUG_PORTS_EN) begin
         next_st = '0; // R10
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign link.prbs_err = st.err;
   assign link.rx_pma_reset_done = st.pma_done;
   assign link.config_port_ready = st.cfg_rdy;
   assign hf_boost_out = st.boost;
   assign eq_state_out = st.eq;
   assign pcs_reset_out = st.pcs_rst;
   assign buf_reset_out = st.buf_rst;
   assign buf_level_out = st.buf_lvl;
endmodule

/* trxd_asserts.sv */
// Purpose: checks on the wires between the two debug port ends
// Assumes: one clock, async active-low reset
// Notes: sees interface signals only, so boost and eq state are left to the bench
`timescale 1ns/10ps
`include "trxd_defines.svh"
module trxd_asserts (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic rx_pcs_reset,
   input wire logic rx_pma_reset,
   input wire logic rx_buf_reset,
   input wire logic rx_full_reset,
   input wire logic rx_pma_reset_done,
   input wire logic [`TRXD_RSVD_W-1:0] pcs_reserved,
   input wire logic config_port_ready,
   input wire logic prbs_err,
   input wire trxd_pkg::trxd_prbs_sel_t prbs_sel
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence pma_rel_s;
      $fell(rx_pma_reset) && !rx_full_reset;
   endsequence
   // done stays low a while, then must come back within a bound
   sequence pma_wait_s;
      !rx_pma_reset_done [*8] ##[4:12] rx_pma_reset_done;
   endsequence
   pcs_pulse_a: assert property (rx_pcs_reset |=> !rx_pcs_reset)
      else $error("pcs reset pulse too long");
   pma_pulse_a: assert property (rx_pma_reset |=> !rx_pma_reset)
      else $error("pma reset pulse too long");
   buf_pulse_a: assert property (rx_buf_reset |=> !rx_buf_reset)
      else $error("buffer reset pulse too long");
   pma_done_low_a: assert property (rx_pma_reset |=> !rx_pma_reset_done)
      else $error("pma done not dropped on request");
   full_done_low_a: assert property (rx_full_reset |=> !rx_pma_reset_done)
      else $error("pma done not dropped on full reset");
   pma_done_time_a: assert property (pma_rel_s |-> pma_wait_s)
      else $error("pma done timing wrong");
   cfg_rst_pulse_a: assert property (pcs_reserved[2] |=> !pcs_reserved[2])
      else $error("config port reset too long");
   // ready is registered, so the stall shows one cycle after the reset bit
   cfg_ready_quiet_a: assert property (pcs_reserved[2] |=> !config_port_ready)
      else $error("ready during config port reset");
   prbs_off_a: assert property ((prbs_sel == 3'h0) [*3] |-> !prbs_err)
      else $error("prbs error with checker off");
endmodule

/* tb_top.sv */
// Purpose: drives both debug port ends joined back to back
// Assumes: 10 MHz clock, inputs driven on rising edge
// Notes: outputs sampled on the falling edge to avoid races
`timescale 1ns/10ps
`include "trxd_defines.svh"
module tb_top;
   logic mclk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, rx_bit_in = 1'b0, cfg_req_in = 1'b0;
   logic boost_override_in = 1'b0, lpm_reset_in = 1'b0, full_reset_in = 1'b0;
   logic [3:0] boost_hold_in = 4'h0;
   logic [2:0] prbs_sel_in = 3'h0;
   logic pcs_reset_req_in = 1'b0, pma_reset_req_in = 1'b0, buf_reset_req_in = 1'b0;
   logic cfg_start_in = 1'b0;
   logic prbs_err_out, pma_done_out, cfg_timeout_out, pcs_reset_out, buf_reset_out;
   logic [3:0] hf_boost_out, eq_state_out;
   logic [7:0] buf_level_out;
   int n_errors = 0, total_checks = 0, cycles = 0, c;
   trxd_if link();
   trxd_user trxd_user_inst (.mclk_in, .rst_n_in, .ce_in, .link, .boost_override_in,
      .boost_hold_in, .lpm_reset_in, .prbs_sel_in, .pcs_reset_req_in, .pma_reset_req_in,
      .buf_reset_req_in, .full_reset_in, .cfg_start_in, .prbs_err_out, .pma_done_out,
      .cfg_timeout_out);
   trxd_dev trxd_dev_inst (.mclk_in, .rst_n_in, .ce_in, .link, .rx_bit_in, .cfg_req_in,
      .hf_boost_out, .eq_state_out, .pcs_reset_out, .buf_reset_out, .buf_level_out);
   trxd_asserts trxd_asserts_inst (.mclk_in, .rst_n_in, .rx_pcs_reset(link.rx_pcs_reset),
      .rx_pma_reset(link.rx_pma_reset), .rx_buf_reset(link.rx_buf_reset),
      .rx_full_reset(link.rx_full_reset), .rx_pma_reset_done(link.rx_pma_reset_done),
      .pcs_reserved(link.pcs_reserved), .config_port_ready(link.config_port_ready),
      .prbs_err(link.prbs_err), .prbs_sel(link.prbs_sel));
   always #50 mclk_in = ~mclk_in;
   always @(posedge mclk_in) rx_bit_in <= ~rx_bit_in;
   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic count_hi(ref logic s, input int n, output int k);
      k = 0;
      repeat (n) begin
         @(negedge mclk_in);
         if (s === 1'b1) k++;
      end
   endtask
   task automatic t_boost;
      @(posedge mclk_in) boost_override_in <= 1'b1;
      boost_hold_in <= 4'h3;
      wait_n(4); check(hf_boost_out, `TRXD_BOOST_CFG_RST);
      @(posedge mclk_in) boost_override_in <= 1'b0;
      wait_n(4); check(hf_boost_out, 4'h3);
      // clock enable low must freeze the boost path
      @(posedge mclk_in) ce_in <= 1'b0;
      boost_override_in <= 1'b1;
      wait_n(4); check(hf_boost_out, 4'h3);
      @(posedge mclk_in) ce_in <= 1'b1;
      boost_override_in <= 1'b0;
      wait_n(4);
      $display("boost test done");
   endtask
   task automatic t_resets;
      @(posedge mclk_in) pcs_reset_req_in <= 1'b1;
      @(posedge mclk_in) pcs_reset_req_in <= 1'b0;
      count_hi(pcs_reset_out, 8, c); check(c, 1);
      @(posedge mclk_in) buf_reset_req_in <= 1'b1;
      @(posedge mclk_in) buf_reset_req_in <= 1'b0;
      count_hi(buf_reset_out, 8, c); check(c, 1);
      check(buf_level_out < 8'h09, 1'b1);
      @(posedge mclk_in) lpm_reset_in <= 1'b1;
      wait_n(4); check(eq_state_out, 4'h0);
      @(posedge mclk_in) lpm_reset_in <= 1'b0;
      $display("reset pulse test done");
   endtask
   task automatic t_pma;
      @(posedge mclk_in) pma_reset_req_in <= 1'b1;
      @(posedge mclk_in) pma_reset_req_in <= 1'b0;
      wait_n(4); check(pma_done_out, 1'b0);
      wait_n(25); check(pma_done_out, 1'b1);
      @(posedge mclk_in) full_reset_in <= 1'b1;
      wait_n(4); check(pma_done_out, 1'b0);
      @(posedge mclk_in) full_reset_in <= 1'b0;
      wait_n(25); check(pma_done_out, 1'b1);
      $display("pma reset test done");
   endtask
   task automatic t_prbs;
      // toggling data against a running checker gives errors on half the cycles
      @(posedge mclk_in) prbs_sel_in <= 3'h1;
      wait_n(4); count_hi(prbs_err_out, 8, c); check(c > 0 && c < 8, 1'b1);
      @(posedge mclk_in) prbs_sel_in <= 3'h0;
      wait_n(4); count_hi(prbs_err_out, 8, c); check(c, 0);
      $display("prbs test done");
   endtask
   task automatic t_cfg;
      @(posedge mclk_in) cfg_start_in <= 1'b1;
      @(posedge mclk_in) cfg_start_in <= 1'b0;
      c = 0;
      while (cfg_timeout_out !== 1'b1 && c < 700) begin
         @(negedge mclk_in);
         c++;
      end
      check(c >= 498 && c <= 503, 1'b1);
      check(link.pcs_reserved[2], 1'b1);
      @(posedge mclk_in) cfg_start_in <= 1'b1;
      @(posedge mclk_in) cfg_start_in <= 1'b0;
      wait_n(5);
      @(posedge mclk_in) cfg_req_in <= 1'b1;
      @(posedge mclk_in) cfg_req_in <= 1'b0;
      count_hi(cfg_timeout_out, 600, c); check(c, 0);
      $display("config port test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ceiling well above the roughly 1250 cycles the tests need
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_boost();
      t_resets();
      t_pma();
      t_prbs();
      t_cfg();
      give_verdict();
   end
endmodule
